// >>> rtl/uart_host_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_host_consts.svh"
module uart_host_bus_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire uart_host_pkg::bus_style_t bus_style,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic bus_style_pin,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] register_address,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in,
  input wire logic irq_in,
  output logic irq_asserted,
  output logic infrared_mode,
  output logic tx_idle_level
);
  import uart_host_pkg::*;

  host_state_t state_reg;
  logic [`CNT_W-1:0] cnt_reg;
  logic write_reg;
  logic [2:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] mcr_shadow_reg;
  logic [7:0] data_sync;
  logic irq_sync;
  logic strobe_mode;

  assign strobe_mode = (bus_style == BUS_STYLE_STROBE);

  pin_sync #(.WIDTH(8)) u_data_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  pin_sync #(.WIDTH(1)) u_irq_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(irq_in),
    .sync_out(irq_sync)
  );

  function automatic logic [`CNT_W-1:0] cyc(input int n);
    cyc = n[`CNT_W-1:0] - 1'b1;
  endfunction

  // ----------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------
  assign req_ready = (state_reg == ST_IDLE);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            state_reg <= ST_SETUP;
            cnt_reg <= cyc(`SETUP_CYC);
          end
        end
        ST_SETUP:
        begin
          if (cnt_reg == '0)
          begin
            state_reg <= ST_STROBE;
            cnt_reg <= cyc(`STROBE_CYC);
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        ST_STROBE:
        begin
          if (cnt_reg == '0)
          begin
            state_reg <= ST_HOLD;
            cnt_reg <= cyc(`HOLD_CYC);
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        ST_HOLD:
        begin
          if (cnt_reg == '0)
            state_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // request capture
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      write_reg <= 1'b0;
      addr_reg <= 3'h0;
      wdata_reg <= 8'h00;
    end
    else if (req_valid && req_ready)
    begin
      write_reg <= req_write;
      addr_reg <= req_addr;
      wdata_reg <= req_wdata;
    end
  end

  // ----------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      chip_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      register_address <= 3'h0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      bus_style_pin <= 1'b1;
    end
    else
    begin
      bus_style_pin <= strobe_mode;
      // select held over setup, strobe and hold
      chip_select_n <= !(state_reg != ST_IDLE || req_valid)
        || (state_reg == ST_HOLD && cnt_reg == '0);
      if (req_valid && req_ready)
        register_address <= req_addr;
      if (strobe_mode)
      begin
        // strobes low one cycle behind the strobe phase, through the first hold cycle
        read_strobe_n <= !(state_reg == ST_STROBE && !write_reg);
        write_strobe_n <= !(state_reg == ST_STROBE && write_reg);
      end
      else
      begin
        read_strobe_n <= 1'b1;
        // direction line: high reads, low writes
        // it moves together with select, so a write is never seen as
        // a read for a cycle and the device never drives against us
        if (state_reg == ST_IDLE)
          write_strobe_n <= !(req_valid && req_write);
        else if (state_reg == ST_HOLD && cnt_reg == '0)
          write_strobe_n <= 1'b1;
        else
          write_strobe_n <= !write_reg;
      end
      // host drives data only for writes
      data_oe <= (state_reg != ST_IDLE) && write_reg
        && !(state_reg == ST_HOLD && cnt_reg == '0);
      data_out <= wdata_reg;
    end
  end

  // ----------------------------------------------------------
  // read return and control shadow
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end
    else
    begin
      // sample at the last strobe cycle, before the rising edge
      rsp_valid <= (state_reg == ST_STROBE) && (cnt_reg == '0)
        && !write_reg;
      if ((state_reg == ST_STROBE) && (cnt_reg == '0) && !write_reg)
        rsp_rdata <= data_sync;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mcr_shadow_reg <= `MCR_RESET_VAL;
    else if (state_reg == ST_STROBE && cnt_reg == '0 && write_reg
      && addr_reg == `MODEM_CTRL_ADDR)
      mcr_shadow_reg <= wdata_reg;
  end

  // ----------------------------------------------------------
  // interrupt and transmit idle interpretation
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_asserted <= 1'b0;
      infrared_mode <= 1'b0;
      tx_idle_level <= 1'b1;
    end
    else
    begin
      if (strobe_mode)
        // active high, only when driven
        irq_asserted <= irq_sync
          && mcr_shadow_reg[`MCR_INT_ENABLE_BIT];
      else
        irq_asserted <= !irq_sync; // open drain, low active
      infrared_mode <= mcr_shadow_reg[`MCR_INFRARED_BIT];
      tx_idle_level <= !mcr_shadow_reg[`MCR_INFRARED_BIT];
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_strobe_needs_cs: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !read_strobe_n || !write_strobe_n |-> !chip_select_n)
    else $error("strobe low without chip select");
  a_dir_read_high: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !$past(strobe_mode) && !strobe_mode |-> read_strobe_n)
    else $error("read strobe low in direction mode");
  a_no_dual_strobe: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !(!read_strobe_n && !write_strobe_n))
    else $error("both strobes low");
  a_read_no_drive: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !read_strobe_n |-> !data_oe)
    else $error("host drives data during read");
  a_write_strobe_len: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $fell(write_strobe_n) && strobe_mode |-> !write_strobe_n [*5])
    else $error("write strobe too short");
  a_tx_idle_lvl: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ##1 tx_idle_level == !$past(mcr_shadow_reg[`MCR_INFRARED_BIT]))
    else $error("tx idle level wrong");
  a_rsp_after_rd: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    rsp_valid |-> !$past(read_strobe_n) || !$past(strobe_mode))
    else $error("response without read");
  a_addr_stable: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !chip_select_n && !$past(chip_select_n) |-> $stable(register_address))
    else $error("address moved during access");
endmodule
`default_nettype wire

// >>> rtl/uart_host_consts.svh
`ifndef UART_HOST_CONSTS_SVH
`define UART_HOST_CONSTS_SVH
// bus timing, in ns, and derived cycle counts at 50 MHz
`define CLK_PERIOD_NS 20
`define SETUP_NS 40
`define STROBE_NS 100
`define HOLD_NS 40
`define SETUP_CYC (((`SETUP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define STROBE_CYC (((`STROBE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define HOLD_CYC (((`HOLD_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CNT_W 4
// modem control register
`define MODEM_CTRL_ADDR 3'h4
`define MCR_INT_ENABLE_BIT 3
`define MCR_INFRARED_BIT 6
`define MCR_RESET_VAL 8'h00
`endif

// >>> rtl/uart_host_pkg.sv
package uart_host_pkg;
  typedef enum logic [1:0] {BUS_STYLE_DIR, BUS_STYLE_STROBE} bus_style_t;
  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} host_state_t;
endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> verification/uart_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_host_consts.svh"
module uart_dev_model (
  input wire logic ref_clk,
  input wire logic bus_style_pin,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] register_address,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic irq_src,
  output logic [7:0] data_bus,
  output logic irq_pin
);
  logic [7:0] regs [8];
  logic [7:0] rd_q, wd;
  logic [2:0] wa;
  logic rd_drive, cs_prev, dir_prev;
  initial foreach (regs[i]) regs[i] = 8'h00;
  // ------------------------------------------------
  // bus side
  // ------------------------------------------------
  assign rd_drive = !chip_select_n
    && (bus_style_pin ? !read_strobe_n : write_strobe_n);
  assign rd_q = regs[register_address];
  // a released bus shows the inverse byte so stale data never passes
  assign data_bus = host_oe ? host_data : rd_drive ? rd_q : ~rd_q;
  always @(posedge write_strobe_n)
    if (bus_style_pin && !chip_select_n)
      regs[register_address] <= data_bus;
  // direction mode commits at select release, from values seen a cycle earlier
  always @(posedge ref_clk)
  begin
    cs_prev <= chip_select_n;
    dir_prev <= write_strobe_n;
    wd <= data_bus;
    wa <= register_address;
    if (!bus_style_pin && !cs_prev && chip_select_n && !dir_prev)
      regs[wa] <= wd;
  end
  // open drain with pull-up in direction mode; floating shows the inverse
  assign irq_pin = !bus_style_pin ? !irq_src
    : regs[`MODEM_CTRL_ADDR][`MCR_INT_ENABLE_BIT] ? irq_src : !irq_src;
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_host_consts.svh"
module tb;
  import uart_host_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  bus_style_t bus_style = BUS_STYLE_STROBE;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [2:0] req_addr = 3'h0;
  logic [7:0] req_wdata = 8'h00;
  logic irq_src = 1'b0;
  logic req_ready, rsp_valid, bus_style_pin, chip_select_n, read_strobe_n;
  logic write_strobe_n, data_oe, irq_pin, irq_asserted, infrared_mode;
  logic tx_idle_level;
  logic [7:0] rsp_rdata, data_out, data_bus;
  logic [2:0] register_address;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #10 ref_clk = ~ref_clk;
  uart_host_bus_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_style(bus_style), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .bus_style_pin(bus_style_pin), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .register_address(register_address), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_bus), .irq_in(irq_pin),
    .irq_asserted(irq_asserted), .infrared_mode(infrared_mode),
    .tx_idle_level(tx_idle_level));
  uart_dev_model i_dev (.ref_clk(ref_clk), .bus_style_pin(bus_style_pin),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .register_address(register_address),
    .host_data(data_out), .host_oe(data_oe), .irq_src(irq_src),
    .data_bus(data_bus), .irq_pin(irq_pin));
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  function automatic logic rd_busy();
    return !chip_select_n
      && (bus_style_pin ? !read_strobe_n : write_strobe_n);
  endfunction
  // contention on the data bus and a stray read strobe in direction mode
  always @(negedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000 || (rst_n && data_oe === 1'b1 && rd_busy())
      || (rst_n && !bus_style_pin && read_strobe_n !== 1'b1))
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time,
        {data_oe, read_strobe_n}, 2'h1);
      miscompares++;
      stop_test;
    end
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic access(input logic wr, input logic [2:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 30)
    begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while ((wr ? req_ready : rsp_valid) !== 1'b1 && n < 30)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_rdata, e);
  endtask
  task automatic do_reset(input bus_style_t s, input logic [7:0] e);
    rst_n = 1'b0;
    bus_style = s;
    repeat (5) @(negedge ref_clk);
    chk({2'h0, bus_style_pin, chip_select_n, read_strobe_n, write_strobe_n,
      data_oe, tx_idle_level}, e);
    rst_n = 1'b1;
  endtask
  task automatic t_rw;
    for (int i = 0; i < 8; i++)
      access(1'b1, 3'(i), 8'h5A ^ (8'(i) * 8'h11));
    for (int i = 0; i < 8; i++)
      rd(3'(i), 8'h5A ^ (8'(i) * 8'h11));
  endtask
  task automatic t_irq(input logic [7:0] e);
    irq_src = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, irq_asserted}, e);
    irq_src = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, irq_asserted}, 8'h00);
  endtask
  task automatic t_ir(input logic [7:0] d, input logic [7:0] e);
    access(1'b1, `MODEM_CTRL_ADDR, d);
    repeat (2) @(negedge ref_clk);
    chk({6'h00, infrared_mode, tx_idle_level}, e);
  endtask
  initial
  begin
    do_reset(BUS_STYLE_STROBE, 8'h3D);
    t_rw;
    access(1'b1, `MODEM_CTRL_ADDR, 8'h08);
    t_irq(8'h01);
    t_ir(8'h40, 8'h02);
    t_ir(8'h00, 8'h01);
    t_irq(8'h00);
    do_reset(BUS_STYLE_DIR, 8'h3D);
    access(1'b1, 3'h2, 8'hC3);
    rd(3'h2, 8'hC3);
    t_irq(8'h01);
    stop_test;
  end
endmodule
`default_nettype wire
